// ==== sltkg_pkg.sv ====
// constants shared by the synthesizer loader and amplifier key guard
// assumes a single 10 MHz system clock and a 32-bit apb register bus
package sltkg_pkg;

  // clock and link timing
  localparam int CLK_NS      = 100;
  localparam int STB_MIN_NS  = 450;
  localparam int STB_MAX_NS  = 1000;
  localparam int STB_MIN_CYC = (STB_MIN_NS + CLK_NS - 1) / CLK_NS;
  localparam int STB_MAX_CYC = STB_MAX_NS / CLK_NS;
  // middle of the window leaves margin at both ends
  localparam int STB_CYC     = (STB_MIN_CYC + STB_MAX_CYC) / 2;
  localparam int BURST_US    = 2000;
  localparam int BURST_CYC   = BURST_US * 1000 / CLK_NS;
  localparam int GAP_MIN_US  = 5000;
  localparam int GAP_MAX_US  = 10000;
  localparam int GAP_CYC     = (GAP_MIN_US + GAP_MAX_US) / 2 * 1000 / CLK_NS;
  localparam int XFERS       = 7;
  localparam int SETUP_CYC   = 2;
  localparam int CNT_W       = 24;

  // register byte offsets
  localparam logic [7:0] OFS_CTRL    = 8'h00;
  localparam logic [7:0] OFS_TX_WORD = 8'h04;
  localparam logic [7:0] OFS_RX_WORD = 8'h08;
  localparam logic [7:0] OFS_CHECK   = 8'h0c;
  localparam logic [7:0] OFS_STATUS  = 8'h10;
  localparam logic [7:0] OFS_INT_ST  = 8'h14;
  localparam logic [7:0] OFS_INT_MSK = 8'h18;

  // control fields
  localparam int CTRL_KEY  = 0;
  localparam int CTRL_LOAD = 1;
  localparam int CTRL_ANT  = 2;
  localparam int CTRL_W    = 3;

  // status fields
  localparam int ST_RX_LOCK = 0;
  localparam int ST_TX_LOCK = 1;
  localparam int ST_AMP_ON  = 2;
  localparam int ST_AMP_FUL = 3;
  localparam int ST_FS      = 4;
  localparam int ST_CFG_OK  = 5;
  localparam int ST_BUSY    = 6;
  localparam int ST_REMOTE  = 8;

  // interrupt fields
  localparam int INT_LOCKLOSS = 0;
  localparam int INT_BURST    = 1;
  localparam int INT_CHKFAIL  = 2;
  localparam int INT_REMOTE   = 3;
  localparam int INT_W        = 4;

  localparam logic [CTRL_W-1:0] CTRL_RST    = 3'h0;
  localparam logic [27:0]       WORD_RST    = 28'h0000000;
  localparam logic [3:0]        CHECK_RST   = 4'h0;
  localparam logic [INT_W-1:0]  INT_MSK_RST = 4'h0;

  typedef enum {S_IDLE, S_SETUP, S_STROBE, S_HOLD, S_GAP} sltkg_seq_t;

endpackage : sltkg_pkg

// ==== sltkg_strobe.sv ====
// one synthesizer strobe: a fire pulse gives one high pulse of fixed width
// assumes fire is not repeated while the pulse is running
module sltkg_strobe
  import sltkg_pkg::*;
#(
  parameter int WIDTH = STB_CYC
) (
  input  wire logic clk_sys,
  input  wire logic nrst,
  input  wire logic fire,
  output logic      strobe,
  output logic      done
);
  logic [3:0] cnt;

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      strobe <= 1'b0;
      cnt    <= 4'h0;
    end else if (fire && !strobe) begin
      strobe <= 1'b1;
      cnt    <= 4'(WIDTH - 1);
    end else if (strobe) begin
      if (cnt == 4'h0) strobe <= 1'b0;
      else cnt <= cnt - 4'h1;
    end
  end

  assign done = strobe && (cnt == 4'h0);

endmodule : sltkg_strobe

// ==== sltkg_top.sv ====
// synthesizer loader and amplifier key guard, apb slave
// assumes status and remote inputs are synchronous to clk_sys
// Function
// - send load bursts of about 2 ms, spaced 5 to 10 ms apart
// - address and data lines change only inside a burst
// - synthesizers capture only on their own strobe pulse
// - exactly seven pulses on each strobe line per burst
// - each strobe pulse lasts 450 ns to 1 us
// - self-check stored configuration at power-up and on test switch
// - key output forced off while watchdog delayed reset is asserted
// - tx lock high during keying sets failsafe latch, ending key at once
// - key stays suppressed until all ptt ended and lock regained
// - latch cleared only by a fresh rising edge of key command
// - antenna relay driven from an options latch bit
// - remote command lines are open collector, pulled up here, read
// - four rf status inputs shown on front panel indicators
// - low on each rf status input means normal condition
module sltkg_top
  import sltkg_pkg::*;
#(
  parameter int BURST_CYCLES = BURST_CYC,
  parameter int GAP_CYCLES   = GAP_CYC,
  parameter int PTT_W        = 3
) (
  input  wire logic             clk_sys,
  input  wire logic             nrst,
  input  wire logic             psel,
  input  wire logic             penable,
  input  wire logic             pwrite,
  input  wire logic [7:0]       paddr,
  input  wire logic [31:0]      pwdata,
  output logic      [31:0]      prdata,
  output logic                  pready,
  output logic                  pslverr,
  output logic                  irq,
  input  wire logic             wd_delayed_rst_n,
  input  wire logic [PTT_W-1:0] ptt_req,
  input  wire logic             test_switch,
  input  wire logic             rx_lock_n,
  input  wire logic             tx_lock_n,
  input  wire logic             amp_active_n,
  input  wire logic             amp_full_output_n,
  input  wire logic [3:0]       remote_cmd_n,
  output logic      [3:0]       remote_pullup_en,
  output logic                  synth_addr_bit0,
  output logic                  synth_addr_bit1,
  output logic                  synth_addr_bit2,
  output logic                  synth_data_bit0,
  output logic                  synth_data_bit1,
  output logic                  synth_data_bit2,
  output logic                  synth_data_bit3,
  output logic                  tx_strobe,
  output logic                  rx_strobe,
  output logic                  amp_keying_out,
  output logic                  ant_relay_out,
  output logic                  led_rx_lock,
  output logic                  led_tx_lock,
  output logic                  led_amp_on,
  output logic                  led_amp_full
);
  localparam int SLOT = BURST_CYCLES / (2 * XFERS);

  function automatic logic [3:0] nib(input logic [27:0] w, input logic [2:0] i);
    nib = w[4*i +: 4];
  endfunction : nib

  // registers
  logic [CTRL_W-1:0] ctrl;
  logic [27:0]       tx_word;
  logic [27:0]       rx_word;
  logic [3:0]        check;
  logic [INT_W-1:0]  int_st;
  logic [INT_W-1:0]  int_msk;
  logic [INT_W-1:0]  ev;
  logic              wr_en;
  logic              rd_en;
  logic              addr_ok;

  // sequencer
  sltkg_seq_t        state;
  logic [CNT_W-1:0]  cnt;
  logic [2:0]        xfer;
  logic              half;
  logic [27:0]       tx_shadow;
  logic [27:0]       rx_shadow;
  logic [2:0]        addr_q;
  logic [3:0]        data_q;
  logic              fire_tx;
  logic              fire_rx;
  logic              done_tx;
  logic              done_rx;
  logic              slot_end;
  logic              last_half;
  logic              start_ok;

  // key guard and checks
  logic              cfg_ok;
  logic              chk_pending;
  logic              test_q;
  logic              key_q;
  logic              fs_latch;
  logic              fs_armed;
  logic              key_rise;
  logic              loss_now;
  logic              next_key;
  logic [3:0]        remote_q;
  logic [3:0]        sum;

  assign wr_en   = psel && penable && pready && pwrite;
  assign rd_en   = psel && penable && !pready;
  assign addr_ok = (paddr == OFS_CTRL) || (paddr == OFS_TX_WORD) || (paddr == OFS_RX_WORD) ||
                   (paddr == OFS_CHECK) || (paddr == OFS_STATUS) || (paddr == OFS_INT_ST) ||
                   (paddr == OFS_INT_MSK);

  // apb: one wait state, so read data and error come from flops
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0;
    end else begin
      pready  <= rd_en;
      // only reads are refused; an unmapped write is dropped without error
      pslverr <= rd_en && !pwrite && !addr_ok;
      if (rd_en && !pwrite) begin
        unique case (paddr)
          OFS_CTRL:    prdata <= {29'h0, ctrl};
          OFS_TX_WORD: prdata <= {4'h0, tx_word};
          OFS_RX_WORD: prdata <= {4'h0, rx_word};
          OFS_CHECK:   prdata <= {28'h0, check};
          OFS_STATUS:  prdata <= {20'h0, remote_q, 1'b0, (state != S_IDLE), cfg_ok, fs_latch,
                                  led_amp_full, led_amp_on, led_tx_lock, led_rx_lock};
          OFS_INT_ST:  prdata <= {28'h0, int_st};
          OFS_INT_MSK: prdata <= {28'h0, int_msk};
          default:     prdata <= 32'h0;
        endcase
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      ctrl    <= CTRL_RST;
      tx_word <= WORD_RST;
      rx_word <= WORD_RST;
      check   <= CHECK_RST;
      int_msk <= INT_MSK_RST;
    end else if (wr_en) begin
      if (paddr == OFS_CTRL) ctrl <= pwdata[CTRL_W-1:0];
      if (paddr == OFS_TX_WORD) tx_word <= pwdata[27:0];
      if (paddr == OFS_RX_WORD) rx_word <= pwdata[27:0];
      if (paddr == OFS_CHECK) check <= pwdata[3:0];
      if (paddr == OFS_INT_MSK) int_msk <= pwdata[INT_W-1:0];
    end
  end

  // sticky events, set wins over a write-one clear in the same cycle
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      int_st <= '0;
    end else begin
      int_st <= (int_st & ~((wr_en && paddr == OFS_INT_ST) ? pwdata[INT_W-1:0] : '0)) | ev;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) irq <= 1'b0;
    else irq <= |(int_st & int_msk);
  end

  // self-check: nibble sum of both stored words must match the check value
  always_comb begin
    sum = 4'h0;
    for (int i = 0; i < XFERS; i++) begin
      sum = sum + nib(tx_word, 3'(i)) + nib(rx_word, 3'(i));
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      chk_pending <= 1'b1;
      cfg_ok      <= 1'b0;
      test_q      <= 1'b0;
    end else begin
      test_q <= test_switch;
      if (chk_pending || (test_switch && !test_q)) begin
        cfg_ok <= (sum == check);
      end
      chk_pending <= 1'b0;
    end
  end

  // burst sequencer
  assign start_ok  = ctrl[CTRL_LOAD] && cfg_ok;
  assign slot_end  = (cnt == CNT_W'(SLOT - 1));
  assign last_half = half && (xfer == 3'(XFERS - 1));
  assign fire_tx   = (state == S_SETUP) && (cnt == CNT_W'(SETUP_CYC - 1)) && !half;
  assign fire_rx   = (state == S_SETUP) && (cnt == CNT_W'(SETUP_CYC - 1)) && half;

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      state     <= S_IDLE;
      cnt       <= '0;
      xfer      <= 3'h0;
      half      <= 1'b0;
      tx_shadow <= WORD_RST;
      rx_shadow <= WORD_RST;
    end else begin
      cnt <= cnt + CNT_W'(1);
      unique case (state)
        S_IDLE: begin
          cnt <= '0;
          if (start_ok) begin
            state     <= S_SETUP;
            xfer      <= 3'h0;
            half      <= 1'b0;
            tx_shadow <= tx_word;
            rx_shadow <= rx_word;
          end
        end
        S_SETUP: if (fire_tx || fire_rx) state <= S_STROBE;
        S_STROBE: if (done_tx || done_rx) state <= S_HOLD;
        S_HOLD: begin
          if (slot_end) begin
            cnt <= '0;
            if (last_half) begin
              state <= S_GAP;
            end else begin
              state <= S_SETUP;
              half  <= !half;
              if (half) xfer <= xfer + 3'h1;
            end
          end
        end
        S_GAP: begin
          if (cnt == CNT_W'(GAP_CYCLES - 1)) begin
            cnt   <= '0;
            state <= start_ok ? S_SETUP : S_IDLE;
            xfer  <= 3'h0;
            half  <= 1'b0;
            tx_shadow <= tx_word;
            rx_shadow <= rx_word;
          end
        end
      endcase
    end
  end

  // lines change only on entry to a setup slot, never in gap or strobe
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      addr_q <= 3'h0;
      data_q <= 4'h0;
    end else if (state == S_SETUP && cnt == '0) begin
      addr_q <= xfer;
      data_q <= half ? nib(rx_shadow, xfer) : nib(tx_shadow, xfer);
    end
  end

  assign {synth_addr_bit2, synth_addr_bit1, synth_addr_bit0} = addr_q;
  assign {synth_data_bit3, synth_data_bit2, synth_data_bit1, synth_data_bit0} = data_q;

  sltkg_strobe #(.WIDTH(STB_CYC)) u_tx_stb (
    .clk_sys (clk_sys),
    .nrst    (nrst),
    .fire    (fire_tx),
    .strobe  (tx_strobe),
    .done    (done_tx)
  );

  sltkg_strobe #(.WIDTH(STB_CYC)) u_rx_stb (
    .clk_sys (clk_sys),
    .nrst    (nrst),
    .fire    (fire_rx),
    .strobe  (rx_strobe),
    .done    (done_rx)
  );

  // amplifier key guard
  assign key_rise = ctrl[CTRL_KEY] && !key_q;
  assign loss_now = amp_keying_out && tx_lock_n;
  assign next_key = ctrl[CTRL_KEY] && wd_delayed_rst_n && !fs_latch && !loss_now;

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      key_q          <= 1'b0;
      fs_latch       <= 1'b0;
      fs_armed       <= 1'b0;
      amp_keying_out <= 1'b0;
    end else begin
      key_q          <= ctrl[CTRL_KEY];
      amp_keying_out <= next_key;
      if (loss_now) begin
        fs_latch <= 1'b1;
        fs_armed <= 1'b0;
      end else if (fs_latch) begin
        // a clear only counts once every ptt has ended and lock is back
        if (ptt_req == '0 && !tx_lock_n) fs_armed <= 1'b1;
        if (fs_armed && key_rise) fs_latch <= 1'b0;
      end
    end
  end

  // indicators, relay, remote lines
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      led_rx_lock      <= 1'b0;
      led_tx_lock      <= 1'b0;
      led_amp_on       <= 1'b0;
      led_amp_full     <= 1'b0;
      ant_relay_out    <= 1'b0;
      remote_pullup_en <= 4'h0;
      remote_q         <= 4'h0;
    end else begin
      led_rx_lock      <= !rx_lock_n;
      led_tx_lock      <= !tx_lock_n;
      led_amp_on       <= !amp_active_n;
      led_amp_full     <= !amp_full_output_n;
      ant_relay_out    <= ctrl[CTRL_ANT];
      remote_pullup_en <= 4'hf;
      remote_q         <= ~remote_cmd_n;
    end
  end

  assign ev[INT_LOCKLOSS] = loss_now;
  assign ev[INT_BURST]    = (state == S_HOLD) && slot_end && last_half;
  assign ev[INT_CHKFAIL]  = (chk_pending || (test_switch && !test_q)) && (sum != check);
  assign ev[INT_REMOTE]   = remote_q != ~remote_cmd_n;

  // helper: tx strobe rises counted per burst
  logic [3:0] stb_cnt;
  logic       tx_prev;
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      stb_cnt <= 4'h0;
      tx_prev <= 1'b0;
    end else begin
      tx_prev <= tx_strobe;
      if (state == S_GAP || state == S_IDLE) stb_cnt <= 4'h0;
      else if (tx_strobe && !tx_prev) stb_cnt <= stb_cnt + 4'h1;
    end
  end

  a_strobe_width: assert property (@(posedge clk_sys) disable iff (!nrst)
    $rose(tx_strobe) |-> tx_strobe [*7] ##1 !tx_strobe) else $error("tx strobe width wrong");
  a_seven_strobes: assert property (@(posedge clk_sys) disable iff (!nrst)
    (state == S_HOLD && slot_end && last_half) |-> stb_cnt == 4'h7)
    else $error("burst did not give seven strobes");
  a_gap_quiet: assert property (@(posedge clk_sys) disable iff (!nrst)
    (state == S_GAP) ##1 (state == S_GAP) |-> $stable({addr_q, data_q}))
    else $error("lines moved between bursts");
  a_stable_strobe: assert property (@(posedge clk_sys) disable iff (!nrst)
    (tx_strobe || rx_strobe) && $past(tx_strobe || rx_strobe) |-> $stable({addr_q, data_q}))
    else $error("lines moved during strobe");
  a_strobe_apart: assert property (@(posedge clk_sys) disable iff (!nrst)
    !(tx_strobe && rx_strobe)) else $error("both strobes high together");
  a_wd_blocks_key: assert property (@(posedge clk_sys) disable iff (!nrst)
    !wd_delayed_rst_n |=> !amp_keying_out) else $error("key during delayed reset");
  a_loss_ends_key: assert property (@(posedge clk_sys) disable iff (!nrst)
    amp_keying_out && tx_lock_n |=> !amp_keying_out && fs_latch)
    else $error("lock loss did not end key");
  a_latch_holds: assert property (@(posedge clk_sys) disable iff (!nrst)
    fs_latch && !key_rise |=> fs_latch) else $error("latch cleared without key edge");
  a_key_causes: assert property (@(posedge clk_sys) disable iff (!nrst)
    amp_keying_out |-> $past(ctrl[CTRL_KEY]) && $past(wd_delayed_rst_n) && !$past(fs_latch))
    else $error("key without its causes");
  a_led_normal: assert property (@(posedge clk_sys) disable iff (!nrst)
    $past(nrst) |-> led_tx_lock == !$past(tx_lock_n)) else $error("tx lock indicator wrong");

endmodule : sltkg_top

// ==== sltkg_rf_model.sv ====
// rf tray model: captures synthesizer loads, drives tx lock and remote lines
// assumes the bench steers lock_loss and remote_drive just after a clock edge
module sltkg_rf_model (
  input  wire logic       clk_sys,
  input  wire logic       tx_strobe,
  input  wire logic       rx_strobe,
  input  wire logic [6:0] lines,
  input  wire logic       lock_loss,
  input  wire logic [3:0] remote_drive,
  input  wire logic [3:0] pullup_en,
  output logic            tx_lock_n,
  output logic [3:0]      remote_cmd_n
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] tx_cap [8];
  logic [3:0] rx_cap [8];
  logic [6:0] held;
  logic [6:0] prev;
  logic [3:0] last  = 4'h0;
  int         t_tx [16];
  int         t_rx [16];
  int         n_tx  = 0;
  int         n_rx  = 0;
  int         w     = 0;
  int         w_min = 1000;
  int         w_max = 0;
  int         bad   = 0;
  int         since = -1;
  int         cyc   = 0;

  assign tx_lock_n = lock_loss;
  // open collector: pulled low when driven; with pull-ups off an undriven line toggles every clock
  assign remote_cmd_n = ~remote_drive & (pullup_en | ~last);

  always @(posedge clk_sys) begin
    cyc++;
    last <= remote_cmd_n;
    // a move of the lines must lead into a strobe, otherwise it lies outside a burst
    if (lines !== prev && cyc > 8) since = 0;
    else if (since >= 0) since++;
    if (since > 3) begin
      bad++;
      since = -1;
    end
    prev = lines;
    if (tx_strobe | rx_strobe) begin
      since = -1;
      if (w == 0) begin
        held = lines;
        if (tx_strobe) begin
          tx_cap[lines[2:0]] = lines[6:3];
          t_tx[n_tx % 16] = cyc;
          n_tx++;
        end else begin
          rx_cap[lines[2:0]] = lines[6:3];
          t_rx[n_rx % 16] = cyc;
          n_rx++;
        end
      end
      if (lines !== held || (tx_strobe & rx_strobe)) bad++;
      w++;
    end else if (w > 0) begin
      if (w < w_min) w_min = w;
      if (w > w_max) w_max = w;
      w = 0;
    end
  end
endmodule : sltkg_rf_model

// ==== sltkg_top_tb.sv ====
// self-checking bench for the synthesizer loader and key guard
// assumes the rf model stands on the synthesizer side; apb driven here
module sltkg_top_tb
  import sltkg_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [27:0] TXW = 28'h1234567;
  localparam logic [27:0] RXW = 28'h89abcde;
  logic clk_sys = 0, nrst = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, irq, err, tx_lock_n, tx_strobe, rx_strobe;
  logic wd_delayed_rst_n = 1, test_switch = 0, rx_lock_n = 0, lock_loss = 0;
  logic amp_active_n = 0, amp_full_output_n = 0;
  logic [2:0] ptt_req = 3'h0;
  logic [3:0] remote_drive = 4'h0, remote_cmd_n, remote_pullup_en;
  logic synth_addr_bit0, synth_addr_bit1, synth_addr_bit2, synth_data_bit0;
  logic synth_data_bit1, synth_data_bit2, synth_data_bit3, amp_keying_out;
  logic ant_relay_out, led_rx_lock, led_tx_lock, led_amp_on, led_amp_full;
  logic [7:0] rows [4] = '{8'h0f, 8'hf0, 8'h5a, 8'ha5};
  int n_mismatch = 0, n_checks = 0, p;

  sltkg_top #(.BURST_CYCLES(140), .GAP_CYCLES(50), .PTT_W(3)) uut (
    .clk_sys, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .irq, .wd_delayed_rst_n, .ptt_req, .test_switch, .rx_lock_n,
    .tx_lock_n, .amp_active_n, .amp_full_output_n, .remote_cmd_n, .remote_pullup_en,
    .synth_addr_bit0, .synth_addr_bit1, .synth_addr_bit2, .synth_data_bit0,
    .synth_data_bit1, .synth_data_bit2, .synth_data_bit3, .tx_strobe, .rx_strobe,
    .amp_keying_out, .ant_relay_out, .led_rx_lock, .led_tx_lock, .led_amp_on,
    .led_amp_full);

  sltkg_rf_model m (
    .clk_sys, .tx_strobe, .rx_strobe, .lock_loss, .remote_drive, .tx_lock_n,
    .remote_cmd_n, .pullup_en(remote_pullup_en),
    .lines({synth_data_bit3, synth_data_bit2, synth_data_bit1, synth_data_bit0,
            synth_addr_bit2, synth_addr_bit1, synth_addr_bit0}));

  always #50 clk_sys = ~clk_sys;

  task automatic conclude();
    $display("checks=%0d mismatches=%0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : conclude

  task automatic limit(input int k);
    if (k >= 1000) begin
      n_mismatch++;
      conclude();
    end
  endtask : limit

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic chk_pin(input logic [3:0] got, input logic [3:0] exp);
    chk({28'h0, got}, {28'h0, exp});
  endtask : chk_pin

  // entered just after a rising edge; returns one edge after completion
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
      k++;
    end while (pready !== 1'b1 && k < 1000);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    limit(k);
    @(posedge clk_sys);
  endtask : apb

  task automatic rdc(input logic [7:0] a, input logic [31:0] msk, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd & msk, e);
  endtask : rdc

  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : tick

  task automatic wait_rx(input int n);
    int k;
    k = 0;
    while (m.n_rx < n && k < 1000) begin
      @(posedge clk_sys);
      k++;
    end
    limit(k);
  endtask : wait_rx

  task automatic selftest();
    test_switch <= 1'b1;
    tick(2);
    test_switch <= 1'b0;
    tick(3);
  endtask : selftest

  initial begin
    tick(6);
    nrst <= 1'b1;
    tick(2);
    rdc(OFS_STATUS, 32'h60, 32'h20);
    rdc(OFS_CTRL, 32'hffffffff, 32'h0);
    rdc(OFS_INT_MSK, 32'hffffffff, 32'h0);
    apb(1'b0, 8'h1c, 32'h0);
    chk({err, rd[30:0]}, 32'h80000000);
    chk_pin(remote_pullup_en, 4'hf);
    $display("test reset done");
    for (int i = 0; i < 4; i++) begin
      {amp_full_output_n, amp_active_n, lock_loss, rx_lock_n} <= rows[i][7:4];
      tick(2);
      chk_pin({led_amp_full, led_amp_on, led_tx_lock, led_rx_lock}, rows[i][3:0]);
      rdc(OFS_STATUS, 32'hf, {28'h0, rows[i][3:0]});
    end
    {amp_full_output_n, amp_active_n, lock_loss, rx_lock_n} <= 4'h0;
    $display("test rows done");
    // check value stays 0 while the nibble sum is 9, so the self-check fails
    apb(1'b1, OFS_TX_WORD, {4'h0, TXW});
    apb(1'b1, OFS_RX_WORD, {4'h0, RXW});
    selftest();
    rdc(OFS_STATUS, 32'h20, 32'h0);
    rdc(OFS_INT_ST, 32'h4, 32'h4);
    chk_pin({3'h0, irq}, 4'h0);
    apb(1'b1, OFS_INT_MSK, 32'h4);
    tick(2);
    chk_pin({3'h0, irq}, 4'h1);
    apb(1'b1, OFS_INT_ST, 32'h4);
    tick(2);
    chk_pin({3'h0, irq}, 4'h0);
    apb(1'b1, OFS_CTRL, 32'h2);
    tick(50);
    chk(m.n_tx, 0);
    $display("test check done");
    apb(1'b1, OFS_CHECK, 32'h9);
    selftest();
    wait_rx(8);
    apb(1'b1, OFS_CTRL, 32'h0);
    wait_rx(14);
    tick(300);
    chk(m.n_tx, 14);
    chk(m.n_rx, 14);
    chk(m.bad, 0);
    chk(m.w_min >= STB_MIN_CYC && m.w_max <= STB_MAX_CYC, 1);
    p = m.t_tx[7] - m.t_tx[0];
    chk(p >= 190 && p <= 200, 1);
    p = m.t_rx[6] - m.t_tx[0];
    chk(p >= 120 && p <= 140, 1);
    for (int i = 0; i < 7; i++)
      chk({m.tx_cap[i], m.rx_cap[i]}, {TXW[4*i+:4], RXW[4*i+:4]});
    rdc(OFS_INT_ST, 32'h3, 32'h2);
    $display("test load done");
    wd_delayed_rst_n <= 1'b0;
    ptt_req <= 3'h1;
    apb(1'b1, OFS_CTRL, 32'h1);
    tick(2);
    chk_pin({3'h0, amp_keying_out}, 4'h0);
    wd_delayed_rst_n <= 1'b1;
    tick(2);
    chk_pin({3'h0, amp_keying_out}, 4'h1);
    lock_loss <= 1'b1;
    tick(2);
    chk_pin({3'h0, amp_keying_out}, 4'h0);
    rdc(OFS_STATUS, 32'h10, 32'h10);
    rdc(OFS_INT_ST, 32'h1, 32'h1);
    lock_loss <= 1'b0;
    apb(1'b1, OFS_CTRL, 32'h0);
    apb(1'b1, OFS_CTRL, 32'h1);
    tick(2);
    chk_pin({3'h0, amp_keying_out}, 4'h0);
    ptt_req <= 3'h0;
    tick(3);
    chk_pin({3'h0, amp_keying_out}, 4'h0);
    apb(1'b1, OFS_CTRL, 32'h0);
    apb(1'b1, OFS_CTRL, 32'h1);
    tick(2);
    chk_pin({3'h0, amp_keying_out}, 4'h1);
    $display("test key done");
    apb(1'b1, OFS_CTRL, 32'h4);
    tick(2);
    chk_pin({3'h0, ant_relay_out}, 4'h1);
    apb(1'b1, OFS_CTRL, 32'h0);
    tick(2);
    chk_pin({3'h0, ant_relay_out}, 4'h0);
    apb(1'b1, OFS_INT_ST, 32'h8);
    rdc(OFS_INT_ST, 32'h8, 32'h0);
    remote_drive <= 4'h5;
    tick(3);
    rdc(OFS_STATUS, 32'hf00, 32'h500);
    rdc(OFS_INT_ST, 32'h8, 32'h8);
    $display("test relay remote done");
    conclude();
  end
endmodule : sltkg_top_tb
